// *** src/cioln_pkg.sv ***
package cioln_pkg;
  // clock period and isolated input mask limits
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MASK_W        = 20;
  localparam logic [19:0] MASK_MAX_NS   = 20'hF4240;  // 1000000 ns
  localparam logic [19:0] MASK_RST      = 20'h00000;
  localparam int          NSLOT         = 5;

  // register offsets
  localparam logic [7:0] A_PICK   = 8'h00;
  localparam logic [7:0] A_DIR    = 8'h04;
  localparam logic [7:0] A_INV    = 8'h08;
  localparam logic [7:0] A_LEVEL  = 8'h0C;
  localparam logic [7:0] A_ALL    = 8'h10;
  localparam logic [7:0] A_ORIGIN = 8'h14;
  localparam logic [7:0] A_FORMAT = 8'h18;
  localparam logic [7:0] A_MASK   = 8'h1C;
  localparam logic [7:0] A_UPICK  = 8'h20;
  localparam logic [7:0] A_UVAL   = 8'h24;
  localparam logic [7:0] A_CHAN   = 8'h28;

  // line picker codes and their storage slots
  localparam logic [5:0] LN_1  = 6'h14;
  localparam logic [5:0] LN_4  = 6'h17;
  localparam logic [5:0] LN_5  = 6'h18;
  localparam logic [5:0] LN_12 = 6'h1F;
  localparam logic [5:0] LN_14 = 6'h21;
  localparam logic [2:0] SL_L1  = 3'h0;
  localparam logic [2:0] SL_L4  = 3'h1;
  localparam logic [2:0] SL_L5  = 3'h2;
  localparam logic [2:0] SL_L12 = 3'h3;
  localparam logic [2:0] SL_L14 = 3'h4;
  localparam logic [4:0]  SLOT_OUT = 5'h09;   // slots 0 and 3 are outputs
  localparam logic [15:0] ALL_USED = 16'h2819; // live bits of the status word

  // output origin codes
  localparam logic [5:0] SRC_NA       = 6'h00;
  localparam logic [5:0] SRC_ACQ      = 6'h01;
  localparam logic [5:0] SRC_FRAME    = 6'h02;
  localparam logic [5:0] SRC_EXP      = 6'h04;
  localparam logic [5:0] SRC_ROW      = 6'h06;
  localparam logic [5:0] SRC_PULSE0   = 6'h07;
  localparam logic [5:0] SRC_PULSE3   = 6'h0A;
  localparam logic [5:0] SRC_USER0    = 6'h0B;
  localparam logic [5:0] SRC_USER3    = 6'h0E;
  localparam logic [5:0] SRC_LOGIC0   = 6'h24;
  localparam logic [5:0] SRC_LOGIC3   = 6'h27;
  localparam logic [5:0] SRC_ENC_TRIG = 6'h28;
  localparam logic [5:0] SRC_ENC_DIR  = 6'h29;
  localparam logic [5:0] SRC_RST      = LN_4;

  // interface types, reset values
  localparam logic [3:0] FMT_TTL   = 4'h2;
  localparam logic [3:0] FMT_ISO   = 4'h5;
  localparam logic [5:0] PICK_RST  = LN_1;
  localparam logic [1:0] UPICK_RST = 2'h0;
  localparam logic [3:0] USER_RST  = 4'h0;

  typedef enum logic [1:0] {
    CH_COMMON = 2'b00,
    CH_RED    = 2'b01,
    CH_GREEN  = 2'b10,
    CH_BLUE   = 2'b11
  } cioln_chan_t;

  // internal camera signals offered as output origins
  typedef struct packed {
    logic       acq_active;
    logic       frame_active;
    logic [2:0] exp_act;     // red, green, blue exposure windows
    logic [1:0] longest_ch;  // channel with longest exposure
    logic       row_valid;
    logic [3:0] pulse;
    logic [3:0] logic_blk;
    logic       enc_trig;
    logic       enc_dir;
  } cioln_src_t;

  function automatic logic line_legal(input logic [5:0] c);
    return (c == LN_1) || (c == LN_4) || (c == LN_5) || (c == LN_12) || (c == LN_14);
  endfunction

  function automatic logic [2:0] line_slot(input logic [5:0] c);
    logic [2:0] s;
    s = SL_L1;
    if (c == LN_4) s = SL_L4;
    if (c == LN_5) s = SL_L5;
    if (c == LN_12) s = SL_L12;
    if (c == LN_14) s = SL_L14;
    return s;
  endfunction
endpackage

// *** src/cioln_src_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
module cioln_src_mux
  import cioln_pkg::*;
(
  input  wire logic [5:0]  code,
  input  wire cioln_src_t  src,
  input  wire cioln_chan_t chan,
  input  wire logic [3:0]  user,
  input  wire logic [2:0]  in_lvl,
  output logic             sig
);
  // exposure window of the chosen channel, common follows the longest
  function automatic logic exp_pick(input cioln_src_t s, input cioln_chan_t c);
    logic [1:0] k;
    k = (c == CH_COMMON) ? s.longest_ch : 2'(c - CH_RED);
    if (k == 2'h3) k = 2'h0;
    return s.exp_act[k];
  endfunction

  // origin code to signal, unlisted codes give low
  always_comb begin
    sig = 1'b0;
    case (code) inside
      SRC_ACQ:                  sig = src.acq_active;
      SRC_FRAME:                sig = src.frame_active;
      SRC_EXP:                  sig = exp_pick(src, chan);
      SRC_ROW:                  sig = src.row_valid;
      [SRC_PULSE0:SRC_PULSE3]:  sig = src.pulse[2'(code - SRC_PULSE0)];
      [SRC_USER0:SRC_USER3]:    sig = user[2'(code - SRC_USER0)];
      LN_4:                     sig = in_lvl[0];
      LN_5:                     sig = in_lvl[1];
      LN_14:                    sig = in_lvl[2];
      [SRC_LOGIC0:SRC_LOGIC3]:  sig = src.logic_blk[2'(code - SRC_LOGIC0)];
      SRC_ENC_TRIG:             sig = src.enc_trig;
      SRC_ENC_DIR:              sig = src.enc_dir;
      default:                  sig = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// *** src/cioln_iso_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module cioln_iso_filter
  import cioln_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [MASK_W-1:0] mask_ns,
  input  wire logic              raw,
  output logic                   filt
);
  logic              filt_r;
  logic              filt_nxt;
  logic [MASK_W-1:0] acc_r;
  logic [MASK_W-1:0] acc_nxt;
  logic [MASK_W:0]   acc_sum;

  // a new level is taken once it has stood for the mask time
  always_comb begin
    acc_sum  = {1'b0, acc_r} + (MASK_W + 1)'(CLK_PERIOD_NS);
    filt_nxt = filt_r;
    acc_nxt  = '0;
    if (raw != filt_r) begin
      if (acc_sum >= {1'b0, mask_ns}) begin
        filt_nxt = raw;
      end else begin
        acc_nxt = acc_sum[MASK_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      filt_r <= 1'b0;
      acc_r  <= '0;
    end else begin
      filt_r <= filt_nxt;
      acc_r  <= acc_nxt;
    end
  end

  assign filt = filt_r;

  mask_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (filt_r != $past(filt_r)) |-> ($past(acc_r) + 20'(CLK_PERIOD_NS) >= $past(mask_ns)))
    else $error("filtered level changed before the mask time");
endmodule
`default_nettype wire

// *** src/cioln_top.sv ***
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module cioln_top
  import cioln_pkg::*;
#(
  parameter bit COLOR_MODEL = 1'b1
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire cioln_src_t  src,
  input  wire logic        ttl_in1,
  input  wire logic        iso_in1,
  input  wire logic        ttl_in4,
  output logic             line1_out,
  output logic             line12_out
);
  logic [5:0]            pick_r;
  logic [5:0]            pick_nxt;
  logic [NSLOT-1:0]      inv_r;
  logic [NSLOT-1:0]      inv_nxt;
  logic [NSLOT-1:0][5:0] org_r;
  logic [NSLOT-1:0][5:0] org_nxt;
  logic [MASK_W-1:0]     mask_r;
  logic [MASK_W-1:0]     mask_nxt;
  logic [1:0]            upick_r;
  logic [1:0]            upick_nxt;
  logic [3:0]            user_r;
  logic [3:0]            user_nxt;
  cioln_chan_t           chan_r;
  cioln_chan_t           chan_nxt;
  logic [31:0]           rdata_r;
  logic [31:0]           rdata_nxt;
  logic [1:0]            out_r;
  logic [1:0]            out_nxt;
  logic [1:0]            drv_src;
  logic [2:0]            slot;
  logic                  src_fixed;
  logic                  iso_filt;
  logic [NSLOT-1:0]      lvl;
  logic [2:0]            in_lvl;
  logic [15:0]           all_lv;
  logic                  dir_now;
  logic                  lvl_now;
  logic [3:0]            fmt_now;

  // picked line decode
  assign slot      = line_slot(pick_r);
  assign src_fixed = (slot == SL_L4) || (slot == SL_L5);
  assign dir_now   = SLOT_OUT[slot];
  assign fmt_now   = (slot == SL_L5) ? FMT_ISO : FMT_TTL;

  // isolated input glitch mask
  cioln_iso_filter u_iso (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .mask_ns (mask_r),
    .raw     (iso_in1),
    .filt    (iso_filt)
  );

  // line levels, inputs seen after their inversion
  assign in_lvl  = {ttl_in4 ^ inv_r[SL_L14], iso_filt ^ inv_r[SL_L5], ttl_in1 ^ inv_r[SL_L4]};
  assign lvl     = {in_lvl[2], out_r[1], in_lvl[1], in_lvl[0], out_r[0]};
  assign lvl_now = lvl[slot];
  // status word: line1 bit0, 4 bit3, 5 bit4, 12 bit11, 14 bit13
  assign all_lv  = {2'h0, lvl[4], 1'b0, lvl[3], 6'h00, lvl[2], lvl[1], 2'h0, lvl[0]};

  // origin multiplexers for the two output lines
  cioln_src_mux u_mux1 (
    .code   (org_r[SL_L1]),
    .src    (src),
    .chan   (chan_r),
    .user   (user_r),
    .in_lvl (in_lvl),
    .sig    (drv_src[0])
  );

  cioln_src_mux u_mux12 (
    .code   (org_r[SL_L12]),
    .src    (src),
    .chan   (chan_r),
    .user   (user_r),
    .in_lvl (in_lvl),
    .sig    (drv_src[1])
  );

  // output drive with polarity flip
  always_comb begin
    out_nxt[0] = drv_src[0] ^ inv_r[SL_L1];
    out_nxt[1] = drv_src[1] ^ inv_r[SL_L12];
  end

  // register writes, illegal picker, user picker and channel values leave the setting unchanged, mask values above the limit clamp to MASK_MAX_NS
  always_comb begin
    pick_nxt  = pick_r;
    inv_nxt   = inv_r;
    org_nxt   = org_r;
    mask_nxt  = mask_r;
    upick_nxt = upick_r;
    user_nxt  = user_r;
    chan_nxt  = chan_r;
    if (reg_wr) begin
      case (reg_addr)
        A_PICK: begin
          if (reg_wdata[31:6] == 26'h0 && line_legal(reg_wdata[5:0])) begin
            pick_nxt = reg_wdata[5:0];
          end
        end
        A_INV:  inv_nxt[slot] = reg_wdata[0];
        A_ORIGIN: begin
          if (!src_fixed && reg_wdata[31:6] == 26'h0) begin
            org_nxt[slot] = reg_wdata[5:0];
          end
        end
        A_MASK: begin
          if (reg_wdata > {12'h000, MASK_MAX_NS}) begin
            mask_nxt = MASK_MAX_NS;
          end else begin
            mask_nxt = reg_wdata[MASK_W-1:0];
          end
        end
        A_UPICK: begin
          if (reg_wdata[31:2] == 30'h0) begin
            upick_nxt = reg_wdata[1:0];
          end
        end
        A_UVAL: user_nxt[upick_r] = reg_wdata[0];
        A_CHAN: begin
          if (reg_wdata[31:2] == 30'h0 && (COLOR_MODEL || reg_wdata[1:0] == 2'h0)) begin
            chan_nxt = cioln_chan_t'(reg_wdata[1:0]);
          end
        end
        default: ;
      endcase
    end
  end

  // read data for the cycle after the strobe, unmapped reads zero
  always_comb begin
    rdata_nxt = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        A_PICK:   rdata_nxt = {26'h0, pick_r};
        A_DIR:    rdata_nxt = {31'h0, dir_now};
        A_INV:    rdata_nxt = {31'h0, inv_r[slot]};
        A_LEVEL:  rdata_nxt = {31'h0, lvl_now};
        A_ALL:    rdata_nxt = {16'h0, all_lv};
        A_ORIGIN: rdata_nxt = {26'h0, src_fixed ? SRC_NA : org_r[slot]};
        A_FORMAT: rdata_nxt = {28'h0, fmt_now};
        A_MASK:   rdata_nxt = {12'h0, mask_r};
        A_UPICK:  rdata_nxt = {30'h0, upick_r};
        A_UVAL:   rdata_nxt = {31'h0, user_r[upick_r]};
        A_CHAN:   rdata_nxt = {30'h0, chan_r};
        default:  rdata_nxt = 32'h0;
      endcase
    end
  end

  // all state registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pick_r  <= PICK_RST;
      inv_r   <= '0;
      org_r   <= {NSLOT{SRC_RST}};
      mask_r  <= MASK_RST;
      upick_r <= UPICK_RST;
      user_r  <= USER_RST;
      chan_r  <= CH_COMMON;
      rdata_r <= 32'h0;
      out_r   <= 2'h0;
    end else begin
      pick_r  <= pick_nxt;
      inv_r   <= inv_nxt;
      org_r   <= org_nxt;
      mask_r  <= mask_nxt;
      upick_r <= upick_nxt;
      user_r  <= user_nxt;
      chan_r  <= chan_nxt;
      rdata_r <= rdata_nxt;
      out_r   <= out_nxt;
    end
  end

  assign reg_rdata  = rdata_r;
  assign line1_out  = out_r[0];
  assign line12_out = out_r[1];

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence rd_of(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence

  sequence wr_of(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  // a picker write that the device must take
  sequence pick_ok;
    wr_of(A_PICK) ##0 (reg_wdata[31:6] == 26'h0 && line_legal(reg_wdata[5:0]));
  endsequence

  // readbacks, line drive and write checks
  picker_legal_a: assert property (line_legal(pick_r))
    else $error("line picker holds an illegal code");
  dir_read_a: assert property (rd_of(A_DIR) |=>
    reg_rdata == {31'h0, ($past(pick_r) == LN_1 || $past(pick_r) == LN_12)})
    else $error("direction readback wrong");
  inv_drive_a: assert property (
    1'b1 |=> line1_out == ($past(drv_src[0]) ^ $past(inv_r[0])))
    else $error("line 1 drive ignores inversion");
  level_read_a: assert property (rd_of(A_LEVEL) |=> reg_rdata == {31'h0, $past(lvl_now)})
    else $error("level readback wrong");
  unused_zero_a: assert property ((all_lv & ~ALL_USED) == 16'h0)
    else $error("unused status bit set");
  origin_drive_a: assert property (
    (org_r[0] == SRC_USER0 && !inv_r[0]) |=> line1_out == $past(user_r[0]))
    else $error("line 1 does not follow user bit 0");
  na_origin_a: assert property (
    rd_of(A_ORIGIN) ##0 src_fixed |=> reg_rdata == {26'h0, SRC_NA})
    else $error("input line origin not fixed");
  format_read_a: assert property (
    rd_of(A_FORMAT) |=> reg_rdata == ($past(slot) == SL_L5 ? 32'h5 : 32'h2))
    else $error("interface type readback wrong");
  upick_range_a: assert property (
    wr_of(A_UPICK) ##0 (reg_wdata > 32'h3) |=> $stable(upick_r))
    else $error("user picker took an out of range value");
  user_write_a: assert property (
    wr_of(A_UVAL) ##0 (upick_r == 2'h2) |=> user_r[2] == $past(reg_wdata[0]))
    else $error("user bit write lost");
  exp_chan_a: assert property (
    (org_r[3] == SRC_EXP && chan_r == CH_BLUE && !inv_r[3])
      |=> line12_out == $past(src.exp_act[2]))
    else $error("exposure channel choice not followed");
  keep_other_a: assert property (
    wr_of(A_INV) ##0 (slot != SL_L1) |=> $stable(inv_r[0]))
    else $error("inversion of another line changed");

  // picker, inversion and origin writes
  pick_write_a: assert property (pick_ok |=> pick_r == $past(reg_wdata[5:0]))
    else $error("legal picker write lost");
  pick_keep_a: assert property (
    wr_of(A_PICK) ##0 !line_legal(reg_wdata[5:0]) |=> $stable(pick_r))
    else $error("illegal picker code taken");
  inv_write_a: assert property (
    wr_of(A_INV) ##0 (slot == SL_L4) |=> inv_r[SL_L4] == $past(reg_wdata[0]))
    else $error("inversion write lost");
  line1_inv_a: assert property (
    (org_r[SL_L1] == LN_4 && inv_r[SL_L1]) |=> line1_out == !$past(ttl_in1 ^ inv_r[SL_L4]))
    else $error("line 1 not inverted");
  origin_write_a: assert property (
    wr_of(A_ORIGIN) ##0 (slot == SL_L1 && reg_wdata < 32'h40)
      |=> org_r[SL_L1] == $past(reg_wdata[5:0]))
    else $error("origin write lost");
  origin_fixed_a: assert property (wr_of(A_ORIGIN) ##0 src_fixed |=> $stable(org_r))
    else $error("input line origin written");
  org_keep_a: assert property (
    wr_of(A_ORIGIN) ##0 (slot != SL_L1) |=> $stable(org_r[SL_L1]))
    else $error("origin of another line changed");

  // status word follows the lines
  status_bits_a: assert property (
    all_lv[0] == line1_out && all_lv[11] == line12_out
      && all_lv[3] == (ttl_in1 ^ inv_r[SL_L4]) && all_lv[13] == (ttl_in4 ^ inv_r[SL_L14]))
    else $error("status word bit misplaced");

  // mask, user picker and channel writes
  mask_clamp_a: assert property (
    wr_of(A_MASK) ##0 (reg_wdata > {12'h000, MASK_MAX_NS}) |=> mask_r == MASK_MAX_NS)
    else $error("mask above its limit not clamped");
  mask_limit_a: assert property (mask_r <= MASK_MAX_NS)
    else $error("mask beyond its limit");
  upick_write_a: assert property (
    wr_of(A_UPICK) ##0 (reg_wdata < 32'h4) |=> upick_r == $past(reg_wdata[1:0]))
    else $error("user picker write lost");
  user_keep_a: assert property (
    wr_of(A_UVAL) ##0 (upick_r != 2'h0) |=> $stable(user_r[0]))
    else $error("user bit of another picker changed");
  common_chan_a: assert property (
    (org_r[SL_L12] == SRC_EXP && chan_r == CH_COMMON && !inv_r[SL_L12]
      && src.longest_ch == 2'h1) |=> line12_out == $past(src.exp_act[1]))
    else $error("common channel does not follow the longest");
  chan_write_a: assert property (
    wr_of(A_CHAN) ##0 (reg_wdata < 32'h4 && COLOR_MODEL)
      |=> chan_r == cioln_chan_t'($past(reg_wdata[1:0])))
    else $error("channel write lost");
  chan_keep_a: assert property (wr_of(A_CHAN) ##0 (reg_wdata > 32'h3) |=> $stable(chan_r))
    else $error("out of range channel taken");
endmodule
`default_nettype wire

// *** sim/cioln_wiring.sv ***
`timescale 1ns/1ps
`default_nettype none
module cioln_wiring (
  input  wire logic       mclk,
  input  wire logic [2:0] lvl,
  input  wire logic [3:0] bounce,
  output logic            ttl_in1,
  output logic            iso_in1,
  output logic            ttl_in4
);
  logic [3:0] left_r;

  // pins start low before the first edge
  initial begin
    left_r  = 4'h0;
    ttl_in1 = 1'b0;
    iso_in1 = 1'b0;
    ttl_in4 = 1'b0;
  end

  // pins follow wanted levels; isolated contact may bounce for a few cycles
  always @(posedge mclk) begin
    ttl_in1 <= lvl[0];
    ttl_in4 <= lvl[2];
    iso_in1 <= lvl[1] ^ ((bounce != 4'h0) || (left_r > 4'h1));
    if (bounce != 4'h0) begin
      left_r <= bounce;
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_camera_io_line_routing.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_camera_io_line_routing;
  import cioln_pkg::*;
  logic        mclk, rst_n, reg_wr, reg_rd, line1_out, line12_out;
  logic        ttl_in1, iso_in1, ttl_in4;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_v;
  logic [2:0]  lvl;
  logic [3:0]  bounce;
  cioln_src_t  src;
  int          num_errors, check_count, i;
  logic [5:0]  codes [5] = '{LN_1, LN_4, LN_5, LN_12, LN_14};
  logic [5:0]  origs [9] = '{6'h01, 6'h02, 6'h06, 6'h07, 6'h0A, 6'h24, 6'h27, 6'h28, 6'h29};

  cioln_top #(.COLOR_MODEL(1'b1)) i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src(src), .ttl_in1(ttl_in1), .iso_in1(iso_in1), .ttl_in4(ttl_in4),
    .line1_out(line1_out), .line12_out(line12_out));

  cioln_wiring i_wiring (.mclk(mclk), .lvl(lvl), .bounce(bounce), .ttl_in1(ttl_in1),
    .iso_in1(iso_in1), .ttl_in4(ttl_in4));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, rd_v);
    chk(rd_v, exp, "register read");
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // only the field behind one origin code is high
  function automatic cioln_src_t one_src(input logic [5:0] c);
    cioln_src_t s;
    s = '0;
    case (c)
      6'h01: s.acq_active = 1'b1;
      6'h02: s.frame_active = 1'b1;
      6'h06: s.row_valid = 1'b1;
      6'h07: s.pulse[0] = 1'b1;
      6'h0A: s.pulse[3] = 1'b1;
      6'h24: s.logic_blk[0] = 1'b1;
      6'h27: s.logic_blk[3] = 1'b1;
      6'h28: s.enc_trig = 1'b1;
      default: s.enc_dir = 1'b1;
    endcase
    return s;
  endfunction

  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    src = '0; lvl = 3'h0; bounce = 4'h0; num_errors = 0; check_count = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values
    rchk(A_PICK, 32'h14);
    rchk(A_DIR, 32'h1);
    rchk(A_INV, 32'h0);
    rchk(A_FORMAT, 32'h2);
    rchk(A_MASK, 32'h0);
    rchk(A_UPICK, 32'h0);
    rchk(A_UVAL, 32'h0);
    rchk(A_CHAN, 32'h0);
    // every picker code, its direction and interface type
    for (i = 0; i < 5; i++) begin
      wr(A_PICK, {26'h0, codes[i]});
      rchk(A_PICK, {26'h0, codes[i]});
      rchk(A_DIR, (i == 0 || i == 3) ? 32'h1 : 32'h0);
      rchk(A_FORMAT, (i == 2) ? 32'h5 : 32'h2);
    end
    wr(A_PICK, 32'h15);
    rchk(A_PICK, {26'h0, LN_14});
    // input levels, status word, outputs on default origin
    lvl <= 3'b101;
    tick(5);
    chk({31'h0, line1_out}, 32'h1, "line1 pin");
    rchk(A_ALL, 32'h2809);
    wr(A_PICK, {26'h0, LN_4});
    rchk(A_LEVEL, 32'h1);
    wr(A_INV, 32'h1);
    rchk(A_LEVEL, 32'h0);
    tick(2);
    rchk(A_ALL, 32'h2000);
    wr(A_PICK, {26'h0, LN_1});
    rchk(A_INV, 32'h0);
    wr(A_INV, 32'h1);
    tick(2);
    chk({31'h0, line1_out}, 32'h1, "line1 double inversion");
    wr(A_INV, 32'h0);
    wr(A_PICK, {26'h0, LN_4});
    wr(A_INV, 32'h0);
    // input lines 4 and 5 keep origin fixed
    wr(A_ORIGIN, 32'h1);
    rchk(A_ORIGIN, 32'h0);
    wr(A_PICK, {26'h0, LN_5});
    wr(A_ORIGIN, 32'h1);
    rchk(A_ORIGIN, 32'h0);
    // user bits routed to line 1, each bit stored apart
    wr(A_PICK, {26'h0, LN_1});
    for (i = 0; i < 4; i++) begin
      wr(A_UPICK, i);
      wr(A_UVAL, i % 2);
      wr(A_ORIGIN, 32'hB + i);
      tick(2);
      chk({31'h0, line1_out}, i % 2, "user bit on line1");
    end
    for (i = 0; i < 4; i++) begin
      wr(A_UPICK, i);
      rchk(A_UVAL, i % 2);
    end
    wr(A_UPICK, 32'h4);
    rchk(A_UPICK, 32'h3);
    // internal signal origins
    for (i = 0; i < 9; i++) begin
      wr(A_ORIGIN, {26'h0, origs[i]});
      src <= one_src(origs[i]);
      tick(3);
      chk({31'h0, line1_out}, 32'h1, "origin high");
      @(posedge mclk);
      src <= '0;
      tick(3);
      chk({31'h0, line1_out}, 32'h0, "origin low");
    end
    // exposure channel choice on line 12, green is the longest
    wr(A_PICK, {26'h0, LN_12});
    wr(A_ORIGIN, 32'h4);
    src.exp_act    <= 3'b010;
    src.longest_ch <= 2'h1;
    for (i = 0; i < 4; i++) begin
      wr(A_CHAN, i);
      tick(2);
      chk({31'h0, line12_out}, (i == 0 || i == 2) ? 32'h1 : 32'h0, "exposure chan");
    end
    wr(A_CHAN, 32'h4);
    rchk(A_CHAN, 32'h3);
    // isolated input mask: clamp, short bounce rejected, long level accepted
    wr(A_MASK, 32'h1E8480);
    rchk(A_MASK, 32'hF4240);
    wr(A_MASK, 32'h1E);
    rchk(A_MASK, 32'h1E);
    @(posedge mclk);
    bounce <= 4'h2;
    @(posedge mclk);
    bounce <= 4'h0;
    rd(A_ALL, rd_v);
    chk(rd_v & 32'h10, 32'h0, "bounce rejected");
    tick(4);
    lvl <= 3'b111;
    tick(8);
    rd(A_ALL, rd_v);
    chk(rd_v & 32'h10, 32'h10, "level accepted");
    // input lines as origins of line 1
    wr(A_PICK, {26'h0, LN_1});
    wr(A_ORIGIN, {26'h0, LN_5});
    tick(2);
    chk({31'h0, line1_out}, 32'h1, "isolated input origin");
    wr(A_ORIGIN, {26'h0, LN_14});
    tick(2);
    chk({31'h0, line1_out}, 32'h1, "line 14 origin high");
    lvl <= 3'b011;
    tick(3);
    chk({31'h0, line1_out}, 32'h0, "line 14 origin low");
    // unmapped and read-only places
    wr(8'h2C, 32'hFFFF);
    rchk(8'h2C, 32'h0);
    wr(A_DIR, 32'h0);
    rchk(A_DIR, 32'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
